// ### logic/trbg_pkg.sv
// Purpose: Shared constants and types for the reload, capture and baud timer.
// Assumes: Registers sit on the byte-wide special function register port.
// Notes:   Every offset, bit position, reset value and count lives here.
//
// What this block does
// - Auto-reload overflow at 0xffff sets overflow flag and interrupt.
// - Each auto-reload overflow loads the counter from the reload pair.
// - Select bit low gives auto-reload; run bit starts counting.
// - Reload mode with trigger enable: trigger edge also reloads.
// - Baud mode reloads on overflow, sets no flag, clocks the UART.
// - Either UART clock select bit forces baud mode with auto-reload.
// - Baud mode, internal timing: counter runs at half the system clock.
// - Baud mode, counter select high: count pin falls form timebase.
// - Baud mode with trigger enable: trigger edge sets external flag.
// - Overflow flag bit 7 is sticky, never set in baud mode.
// - External flag bit 6 set by enabled trigger action, sticky.
// - Receive clock select bit 5 picks this timer for UART receive.
// - Transmit clock select bit 4 picks this timer for UART transmit.
// - Trigger enable bit 3 lets trigger edges act; zero ignores them.
// - Run control bit 2 stops the timer at zero, counts at one.
// - Counter select bit 1: zero internal clock, one count pin edges.
// - Capture/reload select bit 0: capture or reload on trigger edge.
// - Capture bytes take count on capture, else hold reload value.
// - Count bytes form the live counter, readable and writable.
// - Capture mode trigger edge copies count, sets external flag.
// - Internal clock outside baud mode is system clock divided by one or twelve.
package trbg_pkg;

  // --------------------------------------------------------------------
  // Register addresses and reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] TRBG_ADDR_CONTROL  = 8'hc9;
  localparam logic [7:0] TRBG_ADDR_RCAP_LO  = 8'he4;
  localparam logic [7:0] TRBG_ADDR_RCAP_HI  = 8'he5;
  localparam logic [7:0] TRBG_ADDR_COUNT_LO = 8'hf4;
  localparam logic [7:0] TRBG_ADDR_COUNT_HI = 8'hf5;
  localparam logic [7:0] TRBG_RST_CONTROL   = 8'h00;
  localparam logic [7:0] TRBG_RST_RCAP      = 8'h00;
  localparam logic [7:0] TRBG_RST_COUNT     = 8'h00;
  localparam logic [7:0] TRBG_RDATA_UNMAPPED = 8'h00;

  // --------------------------------------------------------------------
  // Control register bit positions
  // --------------------------------------------------------------------
  localparam int TRBG_BIT_OVERFLOW = 7;
  localparam int TRBG_BIT_EXT_FLAG = 6;
  localparam int TRBG_BIT_RX_SEL   = 5;
  localparam int TRBG_BIT_TX_SEL   = 4;
  localparam int TRBG_BIT_EXT_EN   = 3;
  localparam int TRBG_BIT_RUN      = 2;
  localparam int TRBG_BIT_CT_SEL   = 1;
  localparam int TRBG_BIT_CP_RL    = 0;

  // --------------------------------------------------------------------
  // Counts and limits
  // --------------------------------------------------------------------
  localparam logic [3:0]  TRBG_DIV12_LAST = 4'hb;
  localparam logic [15:0] TRBG_COUNT_MAX  = 16'hffff;

  // Control register, field order matches bit 7 down to bit 0.
  typedef struct packed {
    logic overflow_flag;
    logic external_trigger_flag;
    logic uart_rx_clock_select;
    logic uart_tx_clock_select;
    logic external_trigger_enable;
    logic run_control;
    logic counter_timer_select;
    logic capture_reload_select;
  } trbg_ctrl_t;

  // Byte-wide register port request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } trbg_sfr_req_t;

  // Operating mode, Gray coded along off, capture, reload, baud.
  typedef enum logic [1:0] {
    TRBG_MODE_OFF     = 2'b00,
    TRBG_MODE_CAPTURE = 2'b01,
    TRBG_MODE_RELOAD  = 2'b11,
    TRBG_MODE_BAUD    = 2'b10
  } trbg_mode_t;

endpackage : trbg_pkg

// ### logic/trbg_timer.sv
// Purpose: 16-bit timer with capture, auto-reload and UART baud generation.
// Assumes: One clock, synchronous active-low reset, pins asynchronous and synchronised here.
// Notes:   Register reads answer one cycle after the read strobe.
module trbg_timer
  import trbg_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire trbg_sfr_req_t sfr_req,
  output logic [7:0]         sfr_rdata,
  input  wire logic          timer_clock_divide_select,
  input  wire logic          timer_int_enable,
  input  wire logic          count_pin,
  input  wire logic          trigger_pin,
  output logic               timer_irq,
  output logic               uart_rx_tick,
  output logic               uart_tx_tick
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  trbg_ctrl_t  ctrl_ff;
  logic [15:0] count_ff;
  logic [15:0] rcap_ff;
  logic [3:0]  div12_ff;
  logic        half_ff;
  logic [2:0]  cnt_sync_ff;
  logic [2:0]  trg_sync_ff;
  logic [7:0]  rdata_ff;
  logic        irq_ff;
  logic        rx_tick_ff;
  logic        tx_tick_ff;

  trbg_mode_t  mode;
  logic        baud;
  logic        int_tick;
  logic        cnt_fall;
  logic        trg_fall;
  logic        tick;
  logic        ovf;
  logic        trg_act;
  logic        set_tf;
  logic        set_exf;
  logic        do_capture;
  logic        wr_ctrl;
  logic        wr_clo;
  logic        wr_chi;
  logic        wr_rlo;
  logic        wr_rhi;
  logic [15:0] nxt_count;
  trbg_ctrl_t  nxt_ctrl;

  assign wr_ctrl = sfr_req.wr && (sfr_req.addr == TRBG_ADDR_CONTROL);
  assign wr_rlo  = sfr_req.wr && (sfr_req.addr == TRBG_ADDR_RCAP_LO);
  assign wr_rhi  = sfr_req.wr && (sfr_req.addr == TRBG_ADDR_RCAP_HI);
  assign wr_clo  = sfr_req.wr && (sfr_req.addr == TRBG_ADDR_COUNT_LO);
  assign wr_chi  = sfr_req.wr && (sfr_req.addr == TRBG_ADDR_COUNT_HI);

  // --------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------
  // Either UART select bit wins over the capture/reload select bit.
  always_comb begin
    if (!ctrl_ff.run_control) begin
      mode = TRBG_MODE_OFF;
    end else if (ctrl_ff.uart_rx_clock_select ||
                 ctrl_ff.uart_tx_clock_select) begin
      mode = TRBG_MODE_BAUD;
    end else if (ctrl_ff.capture_reload_select) begin
      mode = TRBG_MODE_CAPTURE;
    end else begin
      mode = TRBG_MODE_RELOAD;
    end
  end

  // Baud behaviour of the trigger pin holds even while stopped.
  assign baud = ctrl_ff.uart_rx_clock_select | ctrl_ff.uart_tx_clock_select;

  // --------------------------------------------------------------------
  // Pin synchronisers and falling-edge detect
  // --------------------------------------------------------------------
  // Bit 0 feeds only bit 1; edges are judged from bits 1 and 2.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_sync_ff <= 3'h7;
      trg_sync_ff <= 3'h7;
    end else begin
      cnt_sync_ff <= {cnt_sync_ff[1:0], count_pin};
      trg_sync_ff <= {trg_sync_ff[1:0], trigger_pin};
    end
  end

  assign cnt_fall = cnt_sync_ff[2] & ~cnt_sync_ff[1];
  assign trg_fall = trg_sync_ff[2] & ~trg_sync_ff[1];

  // --------------------------------------------------------------------
  // Internal prescaler
  // --------------------------------------------------------------------
  // Free-running dividers; phase is not reset by the run bit, so the
  // first internal tick after starting may come early by up to 11 cycles.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      div12_ff <= 4'h0;
      half_ff  <= 1'b0;
    end else begin
      div12_ff <= (div12_ff == TRBG_DIV12_LAST) ? 4'h0 : div12_ff + 4'h1;
      half_ff  <= ~half_ff;
    end
  end

  // Baud mode runs off half the clock, else divide by one or twelve.
  always_comb begin
    if (baud) begin
      int_tick = half_ff;
    end else if (timer_clock_divide_select) begin
      int_tick = 1'b1;
    end else begin
      int_tick = (div12_ff == TRBG_DIV12_LAST);
    end
  end

  // Counter select picks the internal tick or count pin edges.
  assign tick = (mode != TRBG_MODE_OFF) &&
                (ctrl_ff.counter_timer_select ? cnt_fall
                                              : int_tick);
  assign ovf  = tick && (count_ff == TRBG_COUNT_MAX);

  // --------------------------------------------------------------------
  // Trigger and flag events
  // --------------------------------------------------------------------
  // An enabled trigger edge acts in every mode; the response differs.
  assign trg_act    = trg_fall && ctrl_ff.external_trigger_enable;
  assign do_capture = trg_act && !baud &&
                      ctrl_ff.capture_reload_select;
  assign set_exf    = trg_act;
  assign set_tf     = ovf && !baud;

  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  // A software byte write overrides the hardware update of that byte.
  always_comb begin
    nxt_count = count_ff;
    if (ovf && (baud || !ctrl_ff.capture_reload_select)) begin
      nxt_count = rcap_ff;
    end else if (trg_act && !baud && !ctrl_ff.capture_reload_select) begin
      nxt_count = rcap_ff;
    end else if (tick) begin
      nxt_count = count_ff + 16'h0001;
    end
    if (wr_clo) begin
      nxt_count[7:0] = sfr_req.wdata;
    end
    if (wr_chi) begin
      nxt_count[15:8] = sfr_req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count_ff <= {TRBG_RST_COUNT, TRBG_RST_COUNT};
    end else begin
      count_ff <= nxt_count;
    end
  end

  // --------------------------------------------------------------------
  // Reload / capture pair
  // --------------------------------------------------------------------
  // A capture wins over a software write in the same cycle, so no
  // measurement is lost.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rcap_ff <= {TRBG_RST_RCAP, TRBG_RST_RCAP};
    end else if (do_capture) begin
      rcap_ff <= count_ff;
    end else begin
      if (wr_rlo) begin
        rcap_ff[7:0] <= sfr_req.wdata;
      end
      if (wr_rhi) begin
        rcap_ff[15:8] <= sfr_req.wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  // Hardware sets win over a software clear in the same cycle.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = trbg_ctrl_t'(sfr_req.wdata);
    end
    if (set_tf) begin
      nxt_ctrl.overflow_flag = 1'b1;
    end
    if (set_exf) begin
      nxt_ctrl.external_trigger_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_ff <= trbg_ctrl_t'(TRBG_RST_CONTROL);
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt and UART shift clock outputs
  // --------------------------------------------------------------------
  // The request follows the flags as they will stand next cycle.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= timer_int_enable && (nxt_ctrl.overflow_flag ||
                nxt_ctrl.external_trigger_flag);
    end
  end

  // Each overflow in baud mode becomes a one-cycle shift clock pulse.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_tick_ff <= 1'b0;
      tx_tick_ff <= 1'b0;
    end else begin
      rx_tick_ff <= ovf && ctrl_ff.uart_rx_clock_select;
      tx_tick_ff <= ovf && ctrl_ff.uart_tx_clock_select;
    end
  end

  // --------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------
  // Reads have no side effects; unmapped addresses return zero.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_ff <= TRBG_RDATA_UNMAPPED;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        TRBG_ADDR_CONTROL:  rdata_ff <= ctrl_ff;
        TRBG_ADDR_RCAP_LO:  rdata_ff <= rcap_ff[7:0];
        TRBG_ADDR_RCAP_HI:  rdata_ff <= rcap_ff[15:8];
        TRBG_ADDR_COUNT_LO: rdata_ff <= count_ff[7:0];
        TRBG_ADDR_COUNT_HI: rdata_ff <= count_ff[15:8];
        default:            rdata_ff <= TRBG_RDATA_UNMAPPED;
      endcase
    end
  end

  assign sfr_rdata    = rdata_ff;
  assign timer_irq    = irq_ff;
  assign uart_rx_tick = rx_tick_ff;
  assign uart_tx_tick = tx_tick_ff;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_half_gap;
    !int_tick ##1 int_tick;
  endsequence

  sequence s_pin_fall;
    trigger_pin ##1 !trigger_pin;
  endsequence

  a_overflow_flag: assert property (
    ovf && !baud |=> ctrl_ff.overflow_flag)
    else $error("Overflow did not set the overflow flag.");

  a_reload_load: assert property (
    ovf && !ctrl_ff.capture_reload_select && !wr_clo && !wr_chi
    |=> count_ff == $past(rcap_ff))
    else $error("Counter did not load the reload value on overflow.");

  a_baud_noflag: assert property (
    baud && !ctrl_ff.overflow_flag && !(wr_ctrl &&
    sfr_req.wdata[TRBG_BIT_OVERFLOW]) |=> !ctrl_ff.overflow_flag)
    else $error("Overflow flag set in baud mode.");

  a_rx_tick: assert property (
    ovf && ctrl_ff.uart_rx_clock_select |=> uart_rx_tick ##1 !uart_rx_tick)
    else $error("Receive shift clock pulse missing or too long.");

  a_tx_tick: assert property (
    uart_tx_tick |-> $past(ovf) && $past(ctrl_ff.uart_tx_clock_select))
    else $error("Transmit shift clock pulse without cause.");

  a_baud_half: assert property (
    baud && int_tick && !(wr_ctrl) |=> s_half_gap)
    else $error("Baud timebase is not half the system clock.");

  a_run_stop: assert property (
    !ctrl_ff.run_control && !trg_act && !wr_clo && !wr_chi
    |=> $stable(count_ff))
    else $error("Counter moved while stopped.");

  a_capture_copy: assert property (
    do_capture |=> rcap_ff == $past(count_ff) &&
    ctrl_ff.external_trigger_flag)
    else $error("Capture did not copy the count or set the flag.");

  a_trig_ignore: assert property (
    !ctrl_ff.external_trigger_enable && !ctrl_ff.external_trigger_flag &&
    !wr_ctrl |=> !ctrl_ff.external_trigger_flag)
    else $error("Trigger edge acted while disabled.");

  a_sync_edge: assert property (
    s_pin_fall ##3 1'b1 |-> $past(trg_fall, 1) || $past(trg_fall, 2))
    else $error("Trigger falling edge not seen after synchroniser.");

  a_irq_flags: assert property (
    timer_irq |-> ctrl_ff.overflow_flag || ctrl_ff.external_trigger_flag)
    else $error("Interrupt request without a flag.");

  a_trig_reload: assert property (
    trg_act && !baud && !ctrl_ff.capture_reload_select && !wr_clo &&
    !wr_chi |=> count_ff == $past(rcap_ff))
    else $error("Trigger edge did not reload the counter.");

  a_baud_extflag: assert property (
    trg_act && baud |=> ctrl_ff.external_trigger_flag)
    else $error("Trigger edge in baud mode did not set the flag.");

  a_rcap_hold: assert property (
    !do_capture && !wr_rlo && !wr_rhi |=> $stable(rcap_ff))
    else $error("Reload value changed without capture or write.");

  a_count_write: assert property (
    wr_clo |=> count_ff[7:0] == $past(sfr_req.wdata))
    else $error("Count low byte write did not land.");

  a_pin_timebase: assert property (
    ctrl_ff.counter_timer_select && !cnt_fall && !trg_act && !wr_clo &&
    !wr_chi |=> $stable(count_ff))
    else $error("Counter moved without a count pin edge.");

endmodule : trbg_timer

// ### verification/trbg_pins_model.sv
// Purpose: Model of the external pins and the UART shift clock receiver.
// Assumes: Pins idle high; every pin change lands on a falling clock edge.
// Notes:   Tick counters wrap at 8 bits, so the bench only uses differences.
module trbg_pins_model (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       uart_rx_tick,
  input  wire logic       uart_tx_tick,
  output logic            count_pin,
  output logic            trigger_pin,
  output logic [7:0]      rx_ticks,
  output logic [7:0]      tx_ticks
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Pin levels and tick counters
  // ------------------------------------------------------------------
  // Both pins rest high so that only commanded pulses make falling edges.
  initial begin
    count_pin   = 1'b1;
    trigger_pin = 1'b1;
  end

  // The shift clock side just counts one-cycle overflow pulses.
  always @(posedge core_clk) begin
    if (!rstn) begin
      rx_ticks <= 8'h00;
      tx_ticks <= 8'h00;
    end else begin
      rx_ticks <= rx_ticks + {7'h00, uart_rx_tick};
      tx_ticks <= tx_ticks + {7'h00, uart_tx_tick};
    end
  end

  // ------------------------------------------------------------------
  // Pin pulses
  // ------------------------------------------------------------------
  // Low and high held three cycles, well past the synchroniser depth.
  task automatic fall_trigger();
    @(negedge core_clk);
    trigger_pin = 1'b0;
    repeat (3) @(negedge core_clk);
    trigger_pin = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask : fall_trigger

  // One falling edge every four cycles, slower than the two-cycle limit.
  task automatic count_falls(input int n);
    repeat (n) begin
      @(negedge core_clk);
      count_pin = 1'b0;
      repeat (2) @(negedge core_clk);
      count_pin = 1'b1;
      @(negedge core_clk);
    end
  endtask : count_falls
endmodule : trbg_pins_model

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the reload, capture and baud timer.
// Assumes: Inputs change on the falling clock edge; reset held 20 cycles.
// Notes:   Internal-timebase tick counts allow one tick of slack; count pin tick counts must be exact.
module tb_top
  import trbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          core_clk;
  logic          rstn;
  logic          div_sel;
  logic          int_en;
  trbg_sfr_req_t sfr_req;
  logic [7:0]    sfr_rdata;
  logic [7:0]    rd_val;
  logic          count_pin;
  logic          trigger_pin;
  logic          timer_irq;
  logic          rx_tick;
  logic          tx_tick;
  logic [7:0]    rx_n;
  logic [7:0]    tx_n;
  int            miscompares;
  int            compares;

  trbg_timer dut_u (.core_clk(core_clk), .rstn(rstn), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .timer_clock_divide_select(div_sel),
    .timer_int_enable(int_en), .count_pin(count_pin),
    .trigger_pin(trigger_pin), .timer_irq(timer_irq),
    .uart_rx_tick(rx_tick), .uart_tx_tick(tx_tick));

  trbg_pins_model pins_u (.core_clk(core_clk), .rstn(rstn),
    .uart_rx_tick(rx_tick),
    .uart_tx_tick(tx_tick), .count_pin(count_pin),
    .trigger_pin(trigger_pin), .rx_ticks(rx_n), .tx_ticks(tx_n));

  // ------------------------------------------------------------------
  // Register port, comparisons and closing
  // ------------------------------------------------------------------
  // The strobe drops one cycle later, so back-to-back calls never clash.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    sfr_req = '0;
  endtask : wr

  // Read data is registered, so it is sampled a full cycle after the edge.
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    sfr_req = '0;
    @(negedge core_clk);
    rd_val = sfr_rdata;
  endtask : rd

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo,
                         input logic [7:0] hi);
    compares++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      miscompares++;
      $display("wrong value at %0t: got %h outside %h..%h", $time, got,
               lo, hi);
    end
  endtask : chk_rng

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // All registers clear, and an unmapped address reads as zero.
  task automatic t_reset();
    logic [7:0] adr [6] = '{8'hc9, 8'he4, 8'he5, 8'hf4, 8'hf5, 8'h33};
    foreach (adr[i]) begin
      rd(adr[i]);
      chk8(rd_val, 8'h00);
    end
  endtask : t_reset

  // Wrap from 0xffff: sticky flag, interrupt, reload from the pair.
  task automatic t_reload();
    int i;
    div_sel = 1'b1;
    int_en  = 1'b1;
    wr(8'he4, 8'hcd);
    wr(8'he5, 8'hab);
    wr(8'hf4, 8'hfe);
    wr(8'hf5, 8'hff);
    wr(8'hc9, 8'h04);
    for (i = 0; i < 20 && timer_irq !== 1'b1; i++) @(negedge core_clk);
    if (i == 20) begin
      miscompares++;
      $display("wrong value at %0t: interrupt never rose", $time);
      final_report();
    end
    rd(8'hc9);
    chk8(rd_val, 8'h84);
    rd(8'hf5);
    chk8(rd_val, 8'hab);
    wr(8'hc9, 8'h04);
    repeat (2) @(negedge core_clk);
    chk8({7'h00, timer_irq}, 8'h00);
    wr(8'hc9, 8'h00);
  endtask : t_reload

  // Trigger edge ignored when disabled, reloads when enabled.
  task automatic t_trigger();
    wr(8'he4, 8'h66);
    wr(8'he5, 8'h55);
    wr(8'hf4, 8'h11);
    wr(8'hf5, 8'h11);
    pins_u.fall_trigger();
    rd(8'hc9);
    chk8(rd_val, 8'h00);
    rd(8'hf4);
    chk8(rd_val, 8'h11);
    wr(8'hc9, 8'h08);
    pins_u.fall_trigger();
    rd(8'hc9);
    chk8(rd_val, 8'h48);
    rd(8'hf5);
    chk8(rd_val, 8'h55);
    chk8({7'h00, timer_irq}, 8'h01);
    wr(8'hc9, 8'h00);
  endtask : t_trigger

  // Capture with the timer stopped: count copied, count itself held.
  task automatic t_capture();
    wr(8'hf4, 8'h68);
    wr(8'hf5, 8'h24);
    wr(8'hc9, 8'h09);
    pins_u.fall_trigger();
    rd(8'he4);
    chk8(rd_val, 8'h68);
    rd(8'he5);
    chk8(rd_val, 8'h24);
    rd(8'hc9);
    chk8(rd_val, 8'h49);
    rd(8'hf4);
    chk8(rd_val, 8'h68);
    wr(8'hc9, 8'h00);
  endtask : t_capture

  // Reload 0xfffe at half rate: one tick per four cycles on chosen sides.
  task automatic t_baud();
    logic [7:0] cfg [3] = '{8'h24, 8'h14, 8'h35};
    logic [7:0] r0;
    logic [7:0] t0;
    int_en = 1'b0;
    wr(8'he4, 8'hfe);
    wr(8'he5, 8'hff);
    // Start near the top, else the first overflow is thousands away.
    wr(8'hf4, 8'hfe);
    wr(8'hf5, 8'hff);
    foreach (cfg[i]) begin
      wr(8'hc9, cfg[i]);
      r0 = rx_n;
      t0 = tx_n;
      repeat (40) @(negedge core_clk);
      chk_rng(rx_n - r0, cfg[i][5] ? 8'h09 : 8'h00,
              cfg[i][5] ? 8'h0b : 8'h00);
      chk_rng(tx_n - t0, cfg[i][4] ? 8'h09 : 8'h00,
              cfg[i][4] ? 8'h0b : 8'h00);
      rd(8'hc9);
      chk8(rd_val, cfg[i]);
    end
    wr(8'hc9, 8'h00);
  endtask : t_baud

  // Count pin as timebase: two falls per overflow; trigger sets flag only.
  task automatic t_baud_ext();
    logic [7:0] r0;
    logic [7:0] t0;
    wr(8'hf4, 8'hfe);
    wr(8'hf5, 8'hff);
    wr(8'hc9, 8'h3e);
    r0 = rx_n;
    t0 = tx_n;
    pins_u.count_falls(10);
    repeat (6) @(negedge core_clk);
    chk_rng(rx_n - r0, 8'h05, 8'h05);
    chk_rng(tx_n - t0, 8'h05, 8'h05);
    pins_u.fall_trigger();
    rd(8'hc9);
    chk8(rd_val, 8'h7e);
    wr(8'hc9, 8'h00);
  endtask : t_baud_ext

  // Divide-by-twelve timebase: about ten counts in 120 cycles.
  task automatic t_div12();
    div_sel = 1'b0;
    wr(8'hf4, 8'h00);
    wr(8'hf5, 8'h00);
    wr(8'hc9, 8'h04);
    repeat (120) @(negedge core_clk);
    wr(8'hc9, 8'h00);
    rd(8'hf4);
    chk_rng(rd_val, 8'h09, 8'h0b);
  endtask : t_div12

  // ------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Cuts a hang short after 20000 cycles, well above the normal run length.
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    $display("wrong value at %0t: run did not finish", $time);
    final_report();
  end

  initial begin
    rstn        = 1'b0;
    div_sel     = 1'b1;
    int_en      = 1'b0;
    sfr_req     = '0;
    miscompares = 0;
    compares    = 0;
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    t_reset();
    t_reload();
    t_trigger();
    t_capture();
    t_baud();
    t_baud_ext();
    t_div12();
    final_report();
  end
endmodule : tb_top
